// ---- verilog/ffc_flag_logic.sv ----
// Flag generation and reset-time configuration for one FIFO bank.
// Assumes write/read clocks and controls arrive as pins, sampled on i_mclk
// which must run well above both; software watches it over APB.
//
// What this block does
// (R1) Capture mode straps during reset, hold until next
// (R2) Read low, write high: fall-through, triple/double buffering
// (R3) Read high, write low: standard, double-buffered boundary flags
// (R4) Both zero: standard, single-buffered; first-load picks almost timing
// (R5) Both one: standard, single, asynchronous almost flags
// (R6) Chain wiring sets first-load and expansion inputs
// (R7) Async almost-empty: falls on read, rises on write
// (R8) Async almost-full: falls on write, rises on read
// (R9) Sync almost-empty changes on read edges only
// (R10) Sync almost-full changes on write edges only
// (R11) Extra buffering delays boundary flags, hides metastability
// (R12) Buffering touches only empty and full flags
// (R13) Standard thresholds from depth, count and offsets
// (R14) Fall-through adds one word, shifted thresholds
// (R15) Default offsets 31, 63 or 127 by depth
// (R16) Offset load alternates empty/full, resumes position
// (R17) Reset clears count, sets flags, loads default offsets
// (R18) Depth is a parameter; thresholds derive from it
`timescale 1ns/10ps
`include "ffc_params.svh"

module ffc_flag_logic #(
    parameter int DEPTH = 256
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // FIFO port pins
    input wire logic i_wclk,
    input wire logic i_rclk,
    input wire logic i_wen_n,
    input wire logic i_ren_n,
    input wire logic i_offset_load_n,
    input wire logic [11:0] i_din,
    // Configuration straps
    input wire logic i_first_load_select,
    input wire logic i_read_expansion_in,
    input wire logic i_write_expansion_in,
    // Flags
    output logic o_empty_flag_n,
    output logic o_full_flag_n,
    output logic o_almost_empty_n,
    output logic o_almost_full_n,
    output logic o_half_full_n,
    output logic o_fall_through_mode,
    output logic o_irq,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [`FFC_ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr
);
    import ffc_pkg::*;

    localparam logic [12:0] DEPTH_W = 13'(DEPTH); // (R18)
    localparam logic [12:0] HALF_W = 13'(DEPTH / 2);
    localparam logic [11:0] OFS_DEF = (DEPTH == 256) ? `FFC_OFS_DEF_256 :
                                      (DEPTH == 512) ? `FFC_OFS_DEF_512 : `FFC_OFS_DEF_BIG; // (R15)

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisation

    logic [`FFC_PIN_W-1:0] pin_raw;
    logic [`FFC_PIN_W-1:0] pin_lvl;
    logic [`FFC_PIN_W-1:0] pin_rise;

    assign pin_raw = {i_write_expansion_in, i_read_expansion_in, i_first_load_select,
                      i_offset_load_n, i_ren_n, i_wen_n, i_rclk, i_wclk, i_din};

    ffc_pin_sync #(
        .W(`FFC_PIN_W)
    ) u_sync (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_pin(pin_raw),
        .o_level(pin_lvl),
        .o_rise(pin_rise)
    );

    logic wclk_ev;
    logic rclk_ev;
    logic wen_n;
    logic ren_n;
    logic ld_n;
    logic [11:0] din;

    assign wclk_ev = pin_rise[`FFC_PIN_WCLK];
    assign rclk_ev = pin_rise[`FFC_PIN_RCLK];
    assign wen_n = pin_lvl[`FFC_PIN_WEN];
    assign ren_n = pin_lvl[`FFC_PIN_REN];
    assign ld_n = pin_lvl[`FFC_PIN_LD];
    assign din = pin_lvl[`FFC_PIN_DIN +: 12];

    ////////////////////////////////////////////////////////////////////////////
    // State

    ffc_state_t s_q;
    ffc_state_t s_d;

    function automatic ffc_cfg_t decode_cfg(input logic fl, input logic read_expansion_in, input logic write_expansion_in);
        ffc_cfg_t c;
        c.fall_through_mode = 1'b0;
        c.sync_almost = fl;
        c.ef_buf = FFC_BUF_SINGLE; // (R4)
        c.ff_buf = FFC_BUF_SINGLE;
        case ({read_expansion_in, write_expansion_in})
            2'b01: begin
                c.fall_through_mode = 1'b1; // (R2)
                c.ef_buf = FFC_BUF_TRIPLE;
                c.ff_buf = FFC_BUF_DOUBLE;
            end
            2'b10: begin
                c.ef_buf = FFC_BUF_DOUBLE; // (R3)
                c.ff_buf = FFC_BUF_DOUBLE;
            end
            2'b11: begin
                c.sync_almost = 1'b0; // (R5)
            end
            default: begin
                c.sync_almost = fl;
            end
        endcase
        return c;
    endfunction : decode_cfg

    function automatic logic pick(input logic [2:0] pipe, input ffc_buf_t depth);
        case (depth)
            FFC_BUF_DOUBLE: pick = pipe[1];
            FFC_BUF_TRIPLE: pick = pipe[2];
            default: pick = pipe[0];
        endcase
    endfunction : pick

    logic [12:0] cap;
    logic wr_ok;
    logic rd_ok;
    logic ofs_load;
    logic [12:0] kn;
    logic [12:0] ae_thr;
    logic [12:0] af_thr;
    logic [12:0] hf_thr;
    logic ae_low;
    logic af_low;
    logic hf_low;
    logic empty_b;
    logic full_b;
    logic [`FFC_IRQ_W-1:0] irq_ev;
    logic [`FFC_IRQ_W-1:0] irq_clr;
    logic apb_access;
    logic apb_done;
    logic apb_mapped;
    logic [31:0] rd_mux;

    always_comb begin
        s_d = s_q;
        // Fall-through counts the output register as one extra word
        cap = s_q.cfg.fall_through_mode ? DEPTH_W + 13'h0001 : DEPTH_W; // (R14)
        wr_ok = wclk_ev && !wen_n && ld_n && (s_q.count != cap);
        rd_ok = rclk_ev && !ren_n && ld_n && (s_q.count != 13'h0000);
        ofs_load = wclk_ev && !wen_n && !ld_n;
        kn = s_q.count + {12'h000, wr_ok} - {12'h000, rd_ok};
        s_d.count = kn;

        // Thresholds
        ae_thr = {1'b0, s_q.empty_ofs} + {12'h000, s_q.cfg.fall_through_mode}; // (R13)
        af_thr = ({1'b0, s_q.full_ofs} > cap) ? 13'h0000 : cap - {1'b0, s_q.full_ofs}; // (R13)
        hf_thr = s_q.cfg.fall_through_mode ? HALF_W + 13'h0002 : HALF_W + 13'h0001; // (R14)
        ae_low = kn <= ae_thr;
        af_low = kn >= af_thr;
        hf_low = kn >= hf_thr;
        empty_b = (kn == 13'h0000);
        full_b = (kn == cap);

        // Boundary pipelines step on their own side's edges
        if (rclk_ev) begin
            s_d.ef_pipe = {s_q.ef_pipe[1:0], empty_b}; // (R11)
        end
        if (wclk_ev) begin
            s_d.ff_pipe = {s_q.ff_pipe[1:0], full_b}; // (R11)
        end
        s_d.ef_n = s_q.cfg.fall_through_mode ? pick(s_d.ef_pipe, s_q.cfg.ef_buf) : !pick(s_d.ef_pipe, s_q.cfg.ef_buf); // (R12)
        s_d.ff_n = s_q.cfg.fall_through_mode ? pick(s_d.ff_pipe, s_q.cfg.ff_buf) : !pick(s_d.ff_pipe, s_q.cfg.ff_buf); // (R12)

        // Partial flags bypass the boundary pipelines
        if (s_q.cfg.sync_almost) begin
            if (rclk_ev) begin
                s_d.ae_n = !ae_low; // (R9)
            end
            if (wclk_ev) begin
                s_d.af_n = !af_low; // (R10)
            end
        end else begin
            if (rclk_ev && ae_low) begin
                s_d.ae_n = 1'b0; // (R7)
            end else if (wclk_ev && !ae_low) begin
                s_d.ae_n = 1'b1; // (R7)
            end
            if (wclk_ev && af_low) begin
                s_d.af_n = 1'b0; // (R8)
            end else if (rclk_ev && !af_low) begin
                s_d.af_n = 1'b1; // (R8)
            end
        end
        if (wclk_ev || rclk_ev) begin
            s_d.hf_n = !hf_low; // (R13)
        end

        // Offset loading keeps its position across load bursts
        if (ofs_load) begin
            if (s_q.ofs_sel == FFC_OFS_EMPTY) begin
                s_d.empty_ofs = din; // (R16)
                s_d.ofs_sel = FFC_OFS_FULL;
            end else begin
                s_d.full_ofs = din; // (R16)
                s_d.ofs_sel = FFC_OFS_EMPTY;
            end
        end

        // APB: one wait state, so read data can come from a flop
        apb_access = i_psel && i_penable;
        apb_done = apb_access && s_q.pready;
        apb_mapped = (i_paddr == `FFC_ADDR_STATUS) || (i_paddr == `FFC_ADDR_LEVEL) ||
                     (i_paddr == `FFC_ADDR_IRQ_STAT) || (i_paddr == `FFC_ADDR_IRQ_MASK) ||
                     (i_paddr == `FFC_ADDR_OFFSETS);
        rd_mux = 32'h0000_0000;
        case (i_paddr)
            `FFC_ADDR_STATUS: begin
                rd_mux[`FFC_ST_EF] = s_q.ef_n;
                rd_mux[`FFC_ST_FF] = s_q.ff_n;
                rd_mux[`FFC_ST_AE] = s_q.ae_n;
                rd_mux[`FFC_ST_HF] = s_q.hf_n;
                rd_mux[`FFC_ST_AF] = s_q.af_n;
                rd_mux[`FFC_ST_FALL_THROUGH_MODE] = s_q.cfg.fall_through_mode;
                rd_mux[`FFC_ST_SYNC] = s_q.cfg.sync_almost;
                rd_mux[`FFC_ST_EFBUF +: 2] = s_q.cfg.ef_buf;
                rd_mux[`FFC_ST_FFBUF +: 2] = s_q.cfg.ff_buf;
            end
            `FFC_ADDR_LEVEL: rd_mux[12:0] = s_q.count;
            `FFC_ADDR_IRQ_STAT: rd_mux[`FFC_IRQ_W-1:0] = s_q.irq_stat;
            `FFC_ADDR_IRQ_MASK: rd_mux[`FFC_IRQ_W-1:0] = s_q.irq_mask;
            `FFC_ADDR_OFFSETS: begin
                rd_mux[11:0] = s_q.empty_ofs;
                rd_mux[`FFC_OFS_FULL_LSB +: 12] = s_q.full_ofs;
            end
            default: rd_mux = 32'h0000_0000;
        endcase
        s_d.pready = apb_access && !s_q.pready;
        s_d.prdata = (apb_access && !s_q.pready && !i_pwrite) ? rd_mux : 32'h0000_0000;
        s_d.pslverr = apb_access && !s_q.pready && !apb_mapped;
        if (apb_done && i_pwrite && (i_paddr == `FFC_ADDR_IRQ_MASK)) begin
            s_d.irq_mask = i_pwdata[`FFC_IRQ_W-1:0];
        end

        // Clear only what the read reported; a new event still sets
        irq_clr = (apb_done && !i_pwrite && (i_paddr == `FFC_ADDR_IRQ_STAT)) ?
                  s_q.prdata[`FFC_IRQ_W-1:0] : '0;
        irq_ev = '0;
        irq_ev[`FFC_IRQ_EMPTY] = empty_b && (s_q.count != 13'h0000);
        irq_ev[`FFC_IRQ_FULL] = full_b && (s_q.count != cap);
        irq_ev[`FFC_IRQ_AE] = s_q.ae_n && !s_d.ae_n;
        irq_ev[`FFC_IRQ_AF] = s_q.af_n && !s_d.af_n;
        s_d.irq_stat = (s_q.irq_stat & ~irq_clr) | irq_ev;
        s_d.irq = |(s_d.irq_stat & s_d.irq_mask);

        if (i_rst) begin
            s_d.cfg = decode_cfg(pin_lvl[`FFC_PIN_FL], pin_lvl[`FFC_PIN_RXI], pin_lvl[`FFC_PIN_WXI]); // (R1)
            s_d.count = 13'h0000; // (R17)
            s_d.empty_ofs = OFS_DEF; // (R17)
            s_d.full_ofs = OFS_DEF;
            s_d.ofs_sel = FFC_OFS_EMPTY;
            s_d.ef_pipe = 3'h7;
            s_d.ff_pipe = 3'h0;
            s_d.ef_n = s_d.cfg.fall_through_mode; // (R17)
            s_d.ff_n = !s_d.cfg.fall_through_mode;
            s_d.ae_n = 1'b0;
            s_d.af_n = 1'b1;
            s_d.hf_n = 1'b1;
            s_d.irq_stat = '0;
            s_d.irq_mask = '0;
            s_d.irq = 1'b0;
            s_d.prdata = 32'h0000_0000;
            s_d.pready = 1'b0;
            s_d.pslverr = 1'b0;
        end
    end

    always_ff @(posedge i_mclk) begin
        s_q <= s_d;
    end

    assign o_empty_flag_n = s_q.ef_n;
    assign o_full_flag_n = s_q.ff_n;
    assign o_almost_empty_n = s_q.ae_n;
    assign o_almost_full_n = s_q.af_n;
    assign o_half_full_n = s_q.hf_n;
    assign o_fall_through_mode = s_q.cfg.fall_through_mode;
    assign o_irq = s_q.irq;
    assign o_prdata = s_q.prdata;
    assign o_pready = s_q.pready;
    assign o_pslverr = s_q.pslverr;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_rst);

    a_cfg_stable: // (R1)
    assert property (!$past(i_rst) |-> $stable(s_q.cfg)) else $error("mode changed outside reset");

    a_fall_through_mode_buffers: // (R2)
    assert property (s_q.cfg.fall_through_mode |-> s_q.cfg.ef_buf == FFC_BUF_TRIPLE && s_q.cfg.ff_buf == FFC_BUF_DOUBLE)
        else $error("fall-through buffering wrong");

    a_std_double: // (R3)
    assert property (@(posedge i_mclk) disable iff (1'b0)
        i_rst && pin_lvl[`FFC_PIN_RXI] && !pin_lvl[`FFC_PIN_WXI] |=>
        !s_q.cfg.fall_through_mode && s_q.cfg.ef_buf == FFC_BUF_DOUBLE && s_q.cfg.ff_buf == FFC_BUF_DOUBLE)
        else $error("double buffering not decoded");

    a_daisy_async: // (R5)
    assert property (@(posedge i_mclk) disable iff (1'b0)
        i_rst && pin_lvl[`FFC_PIN_RXI] && pin_lvl[`FFC_PIN_WXI] |=> !s_q.cfg.sync_almost && !s_q.cfg.fall_through_mode)
        else $error("chain mode not asynchronous");

    a_ae_async_fall: // (R7)
    assert property (!s_q.cfg.sync_almost && $fell(s_q.ae_n) |-> $past(rclk_ev))
        else $error("almost-empty fell without read edge");

    a_af_async_rise: // (R8)
    assert property (!s_q.cfg.sync_almost && $rose(s_q.af_n) |-> $past(rclk_ev))
        else $error("almost-full rose without read edge");

    a_ae_sync_edge: // (R9)
    assert property (s_q.cfg.sync_almost && $changed(s_q.ae_n) |-> $past(rclk_ev))
        else $error("sync almost-empty moved off read edge");

    a_af_sync_edge: // (R10)
    assert property (s_q.cfg.sync_almost && $changed(s_q.af_n) |-> $past(wclk_ev))
        else $error("sync almost-full moved off write edge");

    a_hf_threshold: // (R13)
    assert property (($past(wclk_ev) || $past(rclk_ev)) && !s_q.cfg.fall_through_mode |-> s_q.hf_n == (s_q.count <= HALF_W))
        else $error("half-full threshold wrong");

    a_count_cap: // (R14)
    assert property (s_q.count <= (s_q.cfg.fall_through_mode ? DEPTH_W + 13'h0001 : DEPTH_W))
        else $error("count beyond capacity");

    a_offset_default: // (R15)
    assert property ($past(i_rst) |-> s_q.empty_ofs == OFS_DEF && s_q.full_ofs == OFS_DEF)
        else $error("default offsets not loaded");

    a_offset_toggle: // (R16)
    assert property ($past(ofs_load) |-> s_q.ofs_sel != $past(s_q.ofs_sel))
        else $error("offset load did not alternate");

endmodule : ffc_flag_logic

// ---- inc/ffc_params.svh ----
// Constants for the FIFO flag and reset-time configuration block.
// Assumes inclusion by bare name from the package and design files.
`ifndef FFC_PARAMS_SVH
`define FFC_PARAMS_SVH

// APB register byte addresses
`define FFC_ADDR_W 12
`define FFC_ADDR_STATUS 12'h000
`define FFC_ADDR_LEVEL 12'h004
`define FFC_ADDR_IRQ_STAT 12'h008
`define FFC_ADDR_IRQ_MASK 12'h00C
`define FFC_ADDR_OFFSETS 12'h010

// Default almost-flag offsets per depth
`define FFC_OFS_DEF_256 12'h01F
`define FFC_OFS_DEF_512 12'h03F
`define FFC_OFS_DEF_BIG 12'h07F

// Interrupt status and mask bits
`define FFC_IRQ_W 4
`define FFC_IRQ_EMPTY 0
`define FFC_IRQ_FULL 1
`define FFC_IRQ_AE 2
`define FFC_IRQ_AF 3

// Status register fields
`define FFC_ST_EF 0
`define FFC_ST_FF 1
`define FFC_ST_AE 2
`define FFC_ST_HF 3
`define FFC_ST_AF 4
`define FFC_ST_FALL_THROUGH_MODE 5
`define FFC_ST_SYNC 6
`define FFC_ST_EFBUF 7
`define FFC_ST_FFBUF 9
`define FFC_OFS_FULL_LSB 16

// Pin vector positions through the synchroniser
`define FFC_PIN_W 20
`define FFC_PIN_DIN 0
`define FFC_PIN_WCLK 12
`define FFC_PIN_RCLK 13
`define FFC_PIN_WEN 14
`define FFC_PIN_REN 15
`define FFC_PIN_LD 16
`define FFC_PIN_FL 17
`define FFC_PIN_RXI 18
`define FFC_PIN_WXI 19

`endif

// ---- inc/ffc_pkg.sv ----
// Types for the FIFO flag and reset-time configuration block.
// Assumes ffc_params.svh is on the include path.
`include "ffc_params.svh"

package ffc_pkg;

    typedef enum logic [0:0] {
        FFC_OFS_EMPTY = 1'b0,
        FFC_OFS_FULL = 1'b1
    } ffc_ofs_sel_t;

    // Gray along single, double, triple
    typedef enum logic [1:0] {
        FFC_BUF_SINGLE = 2'b01,
        FFC_BUF_DOUBLE = 2'b11,
        FFC_BUF_TRIPLE = 2'b10
    } ffc_buf_t;

    typedef struct packed {
        logic fall_through_mode;
        logic sync_almost;
        ffc_buf_t ef_buf;
        ffc_buf_t ff_buf;
    } ffc_cfg_t;

    typedef struct packed {
        ffc_cfg_t cfg;
        logic [12:0] count;
        logic [11:0] empty_ofs;
        logic [11:0] full_ofs;
        ffc_ofs_sel_t ofs_sel;
        logic [2:0] ef_pipe;
        logic [2:0] ff_pipe;
        logic ef_n;
        logic ff_n;
        logic ae_n;
        logic af_n;
        logic hf_n;
        logic [`FFC_IRQ_W-1:0] irq_stat;
        logic [`FFC_IRQ_W-1:0] irq_mask;
        logic irq;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } ffc_state_t;

endpackage : ffc_pkg

// ---- verilog/ffc_pin_sync.sv ----
// Three-stage pin synchroniser with agreement filter and rise pulse.
// Assumes pins are asynchronous to i_mclk; no reset on the data stages
// so that strap pins reach the filter while reset is held.
`timescale 1ns/10ps

module ffc_pin_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // Pins
    input wire logic [W-1:0] i_pin,
    // Filtered level and one-cycle rise
    output logic [W-1:0] o_level,
    output logic [W-1:0] o_rise
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
        logic [W-1:0] rise;
    } ffc_sync_state_t;

    ffc_sync_state_t s_q;
    ffc_sync_state_t s_d;
    logic [W-1:0] agree;

    always_comb begin
        agree = ~(s_q.s2 ^ s_q.s3);
        s_d.s1 = i_pin;
        s_d.s2 = s_q.s1;
        s_d.s3 = s_q.s2;
        s_d.lvl = (agree & s_q.s3) | (~agree & s_q.lvl);
        s_d.rise = i_rst ? '0 : (agree & s_q.s3 & ~s_q.lvl);
    end

    always_ff @(posedge i_mclk) begin
        s_q <= s_d;
    end

    assign o_level = s_q.lvl;
    assign o_rise = s_q.rise;

endmodule : ffc_pin_sync

// ---- verif/ffc_fifo_partner.sv ----
// Pin-level writer and reader model for the FIFO flag block.
// Assumes one command at a time from the bench, synchronous to i_mclk.
`timescale 1ns/10ps

module ffc_fifo_partner (
    // Clock
    input wire logic i_mclk,
    // Commands from the bench
    input wire logic i_wr_go,
    input wire logic i_rd_go,
    input wire logic i_en,
    input wire logic i_load,
    input wire logic [1:0] i_gap,
    // FIFO pins
    output logic o_wclk,
    output logic o_rclk,
    output logic o_wen_n,
    output logic o_ren_n,
    output logic o_offset_load_n,
    output logic o_busy
);
    logic [4:0] cnt_q;
    logic wr_q;
    logic rd_q;
    logic [4:0] fall_at;
    logic [4:0] done_at;

    // Gap stretches both clock phases for a slow far side
    assign fall_at = 5'h07 + {3'h0, i_gap};
    assign done_at = 5'h0B + {2'h0, i_gap, 1'h0};

    initial begin
        o_wclk = 1'h0;
        o_rclk = 1'h0;
        o_wen_n = 1'h1;
        o_ren_n = 1'h1;
        o_offset_load_n = 1'h1;
        o_busy = 1'h0;
        cnt_q = 5'h00;
        wr_q = 1'h0;
        rd_q = 1'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Controls settle 4 cycles before the rise, clocks stand low between frames
    always @(posedge i_mclk) begin
        if (!o_busy) begin
            if (i_wr_go || i_rd_go) begin
                o_busy <= 1'h1;
                cnt_q <= 5'h00;
                wr_q <= i_wr_go;
                rd_q <= i_rd_go;
                o_wen_n <= !(i_wr_go && i_en);
                o_ren_n <= !(i_rd_go && i_en);
                o_offset_load_n <= !i_load;
            end
        end else begin
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q == 5'h03) begin
                o_wclk <= wr_q;
                o_rclk <= rd_q;
            end
            if (cnt_q == fall_at) begin
                o_wclk <= 1'h0;
                o_rclk <= 1'h0;
            end
            if (cnt_q == done_at) begin
                o_wen_n <= 1'h1;
                o_ren_n <= 1'h1;
                o_offset_load_n <= 1'h1;
                o_busy <= 1'h0;
            end
        end
    end
endmodule : ffc_fifo_partner

// ---- verif/fifo_flag_config_logic_test.sv ----
// Self-checking bench for the FIFO flag and configuration block.
// Assumes the pin model in ffc_fifo_partner and APB register map of the block.
`timescale 1ns/10ps
`include "ffc_params.svh"

module fifo_flag_config_logic_test;
    import ffc_pkg::*;
    localparam int DEPTH = 256;
    logic mclk = 1'h0, rst = 1'h1, wclk, rclk, wen_n, ren_n, ld_n, fl = 1'h0, read_expansion_in = 1'h0, write_expansion_in = 1'h0;
    logic [11:0] din = 12'h000, paddr = 12'h000;
    logic ef_n, ff_n, ae_n, af_n, hf_n, fall_through_mode, irq, pready, pslverr, busy, errv;
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, wr_go = 1'h0, rd_go = 1'h0, en = 1'h0, load = 1'h0;
    logic [31:0] pwdata = 32'h0, prdata, rdv;
    logic [1:0] gap = 2'h0;
    int fails = 0, comparisons = 0;

    always #5 mclk = ~mclk;

    ffc_flag_logic #(.DEPTH(DEPTH)) ffc_flag_logic_i (.i_mclk(mclk), .i_rst(rst), .i_wclk(wclk), .i_rclk(rclk),
        .i_wen_n(wen_n), .i_ren_n(ren_n), .i_offset_load_n(ld_n), .i_din(din), .i_first_load_select(fl),
        .i_read_expansion_in(read_expansion_in), .i_write_expansion_in(write_expansion_in), .o_empty_flag_n(ef_n), .o_full_flag_n(ff_n),
        .o_almost_empty_n(ae_n), .o_almost_full_n(af_n), .o_half_full_n(hf_n), .o_fall_through_mode(fall_through_mode),
        .o_irq(irq), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr));
    ffc_fifo_partner ffc_fifo_partner_i (.i_mclk(mclk), .i_wr_go(wr_go), .i_rd_go(rd_go), .i_en(en),
        .i_load(load), .i_gap(gap), .o_wclk(wclk), .o_rclk(rclk), .o_wen_n(wen_n), .o_ren_n(ren_n),
        .o_offset_load_n(ld_n), .o_busy(busy));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'h1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (pready !== 1'h1) fails++;
        rdv = prdata;
        errv = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    // One clock pulse on the write and/or read pin, then let the flags settle
    task automatic pulse(input logic w, input logic r, input logic e, input logic l, input logic [11:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        wr_go <= w;
        rd_go <= r;
        en <= e;
        load <= l;
        din <= d;
        @(posedge mclk);
        wr_go <= 1'h0;
        rd_go <= 1'h0;
        do begin
            @(posedge mclk);
            n++;
        end while (busy === 1'h1 && n < 40);
        repeat (4) @(posedge mclk);
    endtask : pulse

    task automatic do_reset(input logic [2:0] s);
        @(posedge mclk);
        {fl, read_expansion_in, write_expansion_in} <= s;
        rst <= 1'h1;
        repeat (8) @(posedge mclk);
        rst <= 1'h0;
        repeat (2) @(posedge mclk);
    endtask : do_reset

    ////////////////////////////////////////////////////////////////////////
    task automatic t_straps;
        logic fw, sy;
        ffc_buf_t eb, fb;
        for (int i = 0; i < 8; i++) begin
            do_reset(i[2:0]);
            fw = !i[1] && i[0];
            sy = i[2] && !(i[1] && i[0]);
            eb = (i[1] && !i[0]) ? FFC_BUF_DOUBLE : FFC_BUF_SINGLE;
            fb = fw ? FFC_BUF_DOUBLE : eb;
            eb = fw ? FFC_BUF_TRIPLE : eb;
            {fl, read_expansion_in, write_expansion_in} <= ~i[2:0];
            repeat (8) @(posedge mclk);
            apb(1'h0, `FFC_ADDR_STATUS, 32'h0);
            check(rdv[10:0], {fb, eb, sy, fw, 1'h1, 1'h1, 1'h0, !fw, fw});
            check(fall_through_mode, fw);
            apb(1'h0, `FFC_ADDR_OFFSETS, 32'h0);
            check(rdv, 32'h001F_001F);
        end
    endtask : t_straps

    task automatic t_offsets;
        do_reset(3'h0);
        pulse(1'h1, 1'h0, 1'h1, 1'h1, 12'h009);
        pulse(1'h1, 1'h0, 1'h1, 1'h1, 12'h003);
        apb(1'h0, `FFC_ADDR_OFFSETS, 32'h0);
        check(rdv, 32'h0003_0009);
        pulse(1'h1, 1'h0, 1'h1, 1'h1, 12'h002);
        apb(1'h0, `FFC_ADDR_OFFSETS, 32'h0);
        check(rdv, 32'h0003_0002);
        apb(1'h0, `FFC_ADDR_LEVEL, 32'h0);
        check(rdv, 32'h0);
        apb(1'h0, 12'h020, 32'h0);
        check(errv, 1'h1);
    endtask : t_offsets

    // Runs with empty offset 2 and full offset 3 from t_offsets
    task automatic t_fill_drain;
        apb(1'h1, `FFC_ADDR_IRQ_MASK, 32'h2);
        check(irq, 1'h0);
        for (int k = 1; k <= DEPTH; k++) begin
            pulse(1'h1, 1'h0, 1'h1, 1'h0, 12'h000);
            check({ff_n, af_n, hf_n, ae_n}, {k != DEPTH, k < DEPTH - 3, k <= DEPTH / 2, k > 2});
        end
        check(irq, 1'h1);
        pulse(1'h1, 1'h0, 1'h1, 1'h0, 12'h000);
        apb(1'h0, `FFC_ADDR_LEVEL, 32'h0);
        check(rdv, DEPTH);
        apb(1'h0, `FFC_ADDR_IRQ_STAT, 32'h0);
        check(rdv[1], 1'h1);
        repeat (2) @(posedge mclk);
        check(irq, 1'h0);
        for (int k = DEPTH - 1; k >= 0; k--) begin
            pulse(1'h0, 1'h1, 1'h1, 1'h0, 12'h000);
            check({ef_n, af_n, hf_n, ae_n}, {k != 0, k < DEPTH - 3, k <= DEPTH / 2, k > 2});
        end
        pulse(1'h0, 1'h1, 1'h1, 1'h0, 12'h000);
        apb(1'h0, `FFC_ADDR_LEVEL, 32'h0);
        check(rdv, 32'h0);
    endtask : t_fill_drain

    task automatic t_sync;
        do_reset(3'h4);
        gap <= 2'h2;
        repeat (32) pulse(1'h1, 1'h0, 1'h1, 1'h0, 12'h000);
        check(ae_n, 1'h0);
        pulse(1'h0, 1'h1, 1'h0, 1'h0, 12'h000);
        check(ae_n, 1'h1);
        gap <= 2'h0;
    endtask : t_sync

    task automatic t_fall_through_mode;
        do_reset(3'h1);
        pulse(1'h1, 1'h0, 1'h1, 1'h0, 12'h000);
        check(ef_n, 1'h1);
        for (int j = 0; j < 3; j++) begin
            pulse(1'h0, 1'h1, 1'h0, 1'h0, 12'h000);
            check(ef_n, j < 2);
        end
        repeat (DEPTH) pulse(1'h1, 1'h0, 1'h1, 1'h0, 12'h000);
        check({ff_n, af_n, hf_n, ae_n}, 4'h1);
        pulse(1'h1, 1'h0, 1'h1, 1'h0, 12'h000);
        check(ff_n, 1'h1);
        apb(1'h0, `FFC_ADDR_LEVEL, 32'h0);
        check(rdv, DEPTH + 1);
    endtask : t_fall_through_mode

    task automatic summarize;
        $display("Comparisons %0d, mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize

    initial begin
        t_straps();
        t_offsets();
        t_fill_drain();
        t_sync();
        t_fall_through_mode();
        summarize();
    end

    // Roughly three times the expected run length
    initial begin
        repeat (45000) @(posedge mclk);
        fails++;
        summarize();
    end
endmodule : fifo_flag_config_logic_test
